//--- wrcm_pkg.sv
// Constants for the watchdog, periodic interrupt and clock monitor block
package wrcm_pkg;

	// Address space and relocatable register window
	localparam int ADDR_W            = 16;
	localparam int WIN_W             = 11;
	localparam int BASE_W            = ADDR_W - WIN_W;
	localparam logic [WIN_W-1:0] WIN_USED_LIMIT = 11'h0200;

	// Register offsets inside the window
	localparam logic [WIN_W-1:0] OFF_PI_CTRL = 11'h0040;
	localparam logic [WIN_W-1:0] OFF_PI_FLAG = 11'h0041;
	localparam logic [WIN_W-1:0] OFF_WD_CTRL = 11'h0042;
	localparam logic [WIN_W-1:0] OFF_WD_KEY  = 11'h0043;

	// Periodic interrupt control fields
	localparam int PIC_IRQ_EN_BIT    = 7;
	localparam int PIC_WAIT_STOP_BIT = 6;
	localparam int PIC_BKG_STOP_BIT  = 5;
	localparam int PIC_BYPASS_BIT    = 4;
	localparam int PIC_RATE_LSB      = 0;

	// Periodic interrupt flag field
	localparam int PIF_FLAG_BIT      = 7;

	// Watchdog and monitor control fields
	localparam int WDC_MON_EN_BIT    = 7;
	localparam int WDC_FMON_EN_BIT   = 6;
	localparam int WDC_FMON_RST_BIT  = 5;
	localparam int WDC_FWD_RST_BIT   = 4;
	localparam int WDC_RST_DIS_BIT   = 3;
	localparam int WDC_RATE_LSB      = 0;

	// Field width and reset values
	localparam int RATE_W            = 3;
	localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;
	localparam logic [7:0] PIC_RESET = 8'h00;
	localparam logic [7:0] WDC_RESET = 8'h00;

	// Service key bytes
	localparam logic [7:0] KEY_ARM     = 8'h55;
	localparam logic [7:0] KEY_RESTART = 8'hAA;

	// Divider chain: first stage 2^13, or 4 in bypass
	localparam int PRE_W             = 13;
	localparam int BYP_W             = 2;
	localparam int PI_CNT_W          = 7;
	localparam int WD_CNT_W          = 10;

	// Service sequence state
	typedef enum logic [0:0] {
		KEY_IDLE  = 1'b0,
		KEY_ARMED = 1'b1
	} wrcm_key_type;

endpackage

//--- wrcm_core.sv
// Watchdog, periodic interrupt and clock monitor supervisory block
// Overview of operation
// RULE_01 - Software writes 55 then AA to service
// RULE_02 - Other accesses between key bytes are allowed
// RULE_03 - Any other key byte resets at once
// RULE_04 - Enabled watchdog timeout causes system reset
// RULE_05 - Watchdog rate: off, 2^13 .. 2^23
// RULE_06 - Stop bits, forced enable, rate write once
// RULE_07 - Bypass, force and disable bits: special only
// RULE_08 - Periodic rate: off, 2^13 .. 2^19
// RULE_09 - Flag sets each period, irq when enabled
// RULE_10 - Writing one clears flag, zero keeps
// RULE_11 - Wait-stop halts both counters in wait
// RULE_12 - Background-stop halts both counters in debug
// RULE_13 - Bypass makes first stage divide by four
// RULE_14 - Enabled monitor resets on lost clock
// RULE_15 - Forced enable holds monitor on until reset
// RULE_16 - Force-monitor bit allows monitor reset
// RULE_17 - Force-watchdog bit allows watchdog reset
// RULE_18 - Reset-disable suppresses both reset sources
// RULE_19 - Software clears monitor enable before stop
// RULE_20 - Register block relocatable on 2K boundaries
// RULE_21 - System reset clears counters, key, flag
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps

module wrcm_core (
	input  wire logic                          clock,       // M-clock
	input  wire logic                          sys_rst,     // Async reset
	input  wire logic [wrcm_pkg::ADDR_W-1:0]   address,     // Bus address
	input  wire logic [7:0]                    wrData,      // Write data
	input  wire logic                          wrStrobe,    // Write strobe
	input  wire logic                          rdStrobe,    // Read strobe
	output logic      [7:0]                    rdData,      // Read data
	input  wire logic [wrcm_pkg::BASE_W-1:0]   blockBase,   // Window base
	input  wire logic                          specialMode, // Special mode
	input  wire logic                          waitMode,    // CPU in wait
	input  wire logic                          bkgMode,     // CPU in debug
	input  wire logic                          clockLost,   // RC detector
	output logic                               periodicIrq, // Irq request
	output logic                               watchdogRst, // Reset pulse
	output logic                               monitorRst   // Reset level
);
	import wrcm_pkg::*;

	// Decode of one register inside the relocatable window
	function automatic logic regHit(
		input logic [ADDR_W-1:0] addr,
		input logic [BASE_W-1:0] base,
		input logic [WIN_W-1:0]  off
	);
		logic inWin;
		inWin = (addr[ADDR_W-1:WIN_W] == base)
			&& (addr[WIN_W-1:0] < WIN_USED_LIMIT);
		regHit = inWin && (addr[WIN_W-1:0] == off);
	endfunction

	// Watchdog post-divider mask for a rate code
	function automatic logic [WD_CNT_W-1:0] wdMask(
		input logic [RATE_W-1:0] rate
	);
		case (rate)
			3'h1:    wdMask = 10'h000;
			3'h2:    wdMask = 10'h003;
			3'h3:    wdMask = 10'h00F;
			3'h4:    wdMask = 10'h03F;
			3'h5:    wdMask = 10'h0FF;
			3'h6:    wdMask = 10'h1FF;
			3'h7:    wdMask = 10'h3FF;
			default: wdMask = 10'h000;
		endcase
	endfunction

	// Periodic post-divider mask for a rate code
	function automatic logic [PI_CNT_W-1:0] piMask(
		input logic [RATE_W-1:0] rate
	);
		case (rate)
			3'h1:    piMask = 7'h00;
			3'h2:    piMask = 7'h01;
			3'h3:    piMask = 7'h03;
			3'h4:    piMask = 7'h07;
			3'h5:    piMask = 7'h0F;
			3'h6:    piMask = 7'h1F;
			3'h7:    piMask = 7'h3F;
			default: piMask = 7'h00;
		endcase
	endfunction

	// Control fields
	logic                irqEn_reg;
	logic                waitStop_reg;
	logic                bkgStop_reg;
	logic                bypass_reg;
	logic [RATE_W-1:0]   piRate_reg;
	logic                monEn_reg;
	logic                fMonEn_reg;
	logic                fMonRst_reg;
	logic                fWdRst_reg;
	logic                rstDis_reg;
	logic [RATE_W-1:0]   wdRate_reg;
	logic                picOnce_reg;
	logic                wdcOnce_reg;

	// Counters, flag and key state
	logic [PRE_W-1:0]    pre_reg;
	logic [PI_CNT_W-1:0] piCnt_reg;
	logic [WD_CNT_W-1:0] wdCnt_reg;
	logic                piFlag_reg;
	wrcm_key_type        key_reg;
	wrcm_key_type        key_next;

	// Bus decode
	logic wrPic;
	logic wrPif;
	logic wrWdc;
	logic wrKey;
	logic picOpen;
	logic wdcOpen;

	// Divider and event terms
	logic halted;
	logic preTick;
	logic piEvent;
	logic wdTimeout;
	logic keyGood;
	logic keyBad;
	logic wdEnabled;
	logic monEnabled;
	logic wdAllowed;
	logic monAllowed;
	logic countEn;
	logic piRateOn;
	logic piMatch;
	logic wdMatch;
	logic flagClr;
	logic keyArm;
	logic keyRestart;
	logic fMonWr;
	logic wdRstNext;
	logic monRstNext;

	// Read mux output
	logic [7:0] rdNext;

	// Register strobes; window base moves the block
	assign wrPic = wrStrobe && regHit(address, blockBase, OFF_PI_CTRL); // see RULE_20
	assign wrPif = wrStrobe && regHit(address, blockBase, OFF_PI_FLAG);
	assign wrWdc = wrStrobe && regHit(address, blockBase, OFF_WD_CTRL);
	assign wrKey = wrStrobe && regHit(address, blockBase, OFF_WD_KEY);

	// Once-only fields stay open until first write in normal modes
	assign picOpen = specialMode || !picOnce_reg; // see RULE_06
	assign wdcOpen = specialMode || !wdcOnce_reg; // see RULE_06

	// Forced enable sets once; only special modes may clear it
	assign fMonWr = wdcOpen
		&& (specialMode || wrData[WDC_FMON_EN_BIT]); // see RULE_15

	// Periodic control; enable and rate always writable
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			irqEn_reg    <= PIC_RESET[PIC_IRQ_EN_BIT];
			piRate_reg   <= PIC_RESET[PIC_RATE_LSB +: RATE_W];
			waitStop_reg <= PIC_RESET[PIC_WAIT_STOP_BIT];
			bkgStop_reg  <= PIC_RESET[PIC_BKG_STOP_BIT];
			bypass_reg   <= PIC_RESET[PIC_BYPASS_BIT];
			picOnce_reg  <= 1'b0;
		end else if (wrPic) begin
			irqEn_reg  <= wrData[PIC_IRQ_EN_BIT];
			piRate_reg <= wrData[PIC_RATE_LSB +: RATE_W];
			picOnce_reg <= 1'b1;
			if (picOpen) begin
				waitStop_reg <= wrData[PIC_WAIT_STOP_BIT]; // see RULE_06
				bkgStop_reg  <= wrData[PIC_BKG_STOP_BIT];  // see RULE_06
			end
			if (specialMode) begin
				bypass_reg <= wrData[PIC_BYPASS_BIT]; // see RULE_07
			end
		end
	end

	// Watchdog and monitor control
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			monEn_reg   <= WDC_RESET[WDC_MON_EN_BIT];
			fMonEn_reg  <= WDC_RESET[WDC_FMON_EN_BIT];
			fMonRst_reg <= WDC_RESET[WDC_FMON_RST_BIT];
			fWdRst_reg  <= WDC_RESET[WDC_FWD_RST_BIT];
			rstDis_reg  <= WDC_RESET[WDC_RST_DIS_BIT];
			wdRate_reg  <= WDC_RESET[WDC_RATE_LSB +: RATE_W];
			wdcOnce_reg <= 1'b0;
		end else if (wrWdc) begin
			monEn_reg   <= wrData[WDC_MON_EN_BIT];
			wdcOnce_reg <= 1'b1;
			if (wdcOpen) begin
				wdRate_reg <= wrData[WDC_RATE_LSB +: RATE_W]; // see RULE_06
			end
			if (fMonWr) begin
				fMonEn_reg <= wrData[WDC_FMON_EN_BIT]; // see RULE_15
			end
			if (specialMode) begin
				fMonRst_reg <= wrData[WDC_FMON_RST_BIT]; // see RULE_07
				fWdRst_reg  <= wrData[WDC_FWD_RST_BIT];  // see RULE_07
				rstDis_reg  <= wrData[WDC_RST_DIS_BIT];  // see RULE_07
			end
		end
	end

	// Low-power and debug freezes apply to both counters
	assign halted = (waitStop_reg && waitMode) // see RULE_11
		|| (bkgStop_reg && bkgMode);           // see RULE_12

	// First stage tick: full 2^13 or short 4-cycle test path
	assign preTick = bypass_reg ? (&pre_reg[BYP_W-1:0]) // see RULE_13
		: (&pre_reg);

	// Shared first stage divider
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pre_reg <= '0; // see RULE_21
		end else if (!halted) begin
			pre_reg <= preTick ? '0 : pre_reg + 1'b1;
		end
	end

	// Both post-dividers advance only on a live prescaler tick
	assign countEn = !halted && preTick; // see RULE_11 RULE_12

	// Periodic event when all selected low bits are set
	assign piRateOn = (piRate_reg != RATE_OFF); // see RULE_08
	assign piMatch  = (piCnt_reg & piMask(piRate_reg)) == piMask(piRate_reg);
	assign piEvent  = countEn && piRateOn && piMatch;

	// Periodic post-divider runs freely
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			piCnt_reg <= '0; // see RULE_21
		end else if (countEn) begin
			piCnt_reg <= piCnt_reg + 1'b1;
		end
	end

	// Clear request: only a one in the flag position counts
	assign flagClr = wrPif && wrData[PIF_FLAG_BIT]; // see RULE_10

	// Flag: a new timeout beats a same-cycle clear
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			piFlag_reg <= 1'b0; // see RULE_21
		end else if (piEvent) begin
			piFlag_reg <= 1'b1; // see RULE_09
		end else if (flagClr) begin
			piFlag_reg <= 1'b0; // see RULE_10
		end
	end

	// Interrupt request is a pure level of flag and enable
	assign periodicIrq = piFlag_reg && irqEn_reg; // see RULE_09

	// Key byte classes
	assign keyArm     = wrKey && (wrData == KEY_ARM);
	assign keyRestart = wrKey && (wrData == KEY_RESTART);

	// Service key decode; reads and other writes leave state alone
	assign keyGood = keyRestart && (key_reg == KEY_ARMED); // see RULE_01
	assign keyBad  = wrKey && !keyArm && !keyRestart;      // see RULE_03

	// Service sequence next state
	always_comb begin
		key_next = key_reg;
		case (key_reg)
			KEY_IDLE: begin
				if (wrKey && wrData == KEY_ARM) begin
					key_next = KEY_ARMED;
				end
			end
			KEY_ARMED: begin
				// Unrelated accesses keep the arm pending
				if (wrKey && wrData == KEY_RESTART) begin
					key_next = KEY_IDLE; // see RULE_02
				end else if (keyBad) begin
					key_next = KEY_IDLE;
				end
			end
			default: key_next = KEY_IDLE;
		endcase
	end

	// Service sequence state
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			key_reg <= KEY_IDLE; // see RULE_21
		end else begin
			key_reg <= key_next;
		end
	end

	// Rate code zero switches the watchdog off and clears its count
	assign wdEnabled = (wdRate_reg != RATE_OFF); // see RULE_05

	// Watchdog timeout on a live tick at the selected count
	assign wdMatch   = (wdCnt_reg & wdMask(wdRate_reg)) == wdMask(wdRate_reg);
	assign wdTimeout = wdEnabled && countEn && wdMatch; // see RULE_04

	// Watchdog post-divider; service restarts it, prescaler keeps phase
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wdCnt_reg <= '0; // see RULE_21
		end else if (!wdEnabled || keyGood) begin
			wdCnt_reg <= '0; // see RULE_01
		end else if (countEn) begin
			wdCnt_reg <= wdCnt_reg + 1'b1;
		end
	end

	// Reset gating: disable wins; special modes need the force bits
	assign wdAllowed  = !rstDis_reg
		&& (!specialMode || fWdRst_reg);  // see RULE_17 RULE_18
	assign monAllowed = !rstDis_reg
		&& (!specialMode || fMonRst_reg); // see RULE_16 RULE_18

	// Monitor is on by its own bit or by the sticky forced bit
	assign monEnabled = fMonEn_reg || monEn_reg; // see RULE_15

	// Reset requests ahead of the output flops
	assign wdRstNext  = wdAllowed && (wdTimeout || keyBad); // see RULE_04
	assign monRstNext = monAllowed && monEnabled && clockLost; // see RULE_14

	// Watchdog reset pulse from timeout or wrong key
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			watchdogRst <= 1'b0;
		end else begin
			watchdogRst <= wdRstNext;
		end
	end

	// Monitor reset; detector runs without clocks, so no edge may
	// follow a lost clock and the level must act as an async request
	// in the reset controller outside this block
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			monitorRst <= 1'b0;
		end else begin
			monitorRst <= monRstNext;
		end
	end

	// Read mux; the key register and unmapped addresses read zero
	always_comb begin
		if (!rdStrobe) begin
			rdNext = 8'h00;
		end else if (regHit(address, blockBase, OFF_PI_CTRL)) begin
			rdNext = {irqEn_reg, waitStop_reg, bkgStop_reg, bypass_reg,
				1'b0, piRate_reg};
		end else if (regHit(address, blockBase, OFF_PI_FLAG)) begin
			rdNext = {piFlag_reg, 7'h00};
		end else if (regHit(address, blockBase, OFF_WD_CTRL)) begin
			rdNext = {monEn_reg, fMonEn_reg, fMonRst_reg, fWdRst_reg,
				rstDis_reg, wdRate_reg};
		end else begin
			rdNext = 8'h00;
		end
	end

	// Read data register; stands for one cycle only
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdData <= 8'h00;
		end else begin
			rdData <= rdNext;
		end
	end

endmodule // wrcm_core

//--- wrcm_core_chk.sv
// Port-level assertions for the supervisory block
`timescale 1ns/10ps
module wrcm_core_chk (
	input wire logic                        clock,       // M-clock
	input wire logic                        sys_rst,     // Reset
	input wire logic [wrcm_pkg::ADDR_W-1:0] address,     // Address
	input wire logic [7:0]                  wrData,      // Write data
	input wire logic                        wrStrobe,    // Write
	input wire logic                        rdStrobe,    // Read
	input wire logic [7:0]                  rdData,      // Read data
	input wire logic [wrcm_pkg::BASE_W-1:0] blockBase,   // Base
	input wire logic                        specialMode, // Special
	input wire logic                        waitMode,    // Wait
	input wire logic                        bkgMode,     // Debug
	input wire logic                        clockLost,   // Lost clock
	input wire logic                        periodicIrq, // Irq
	input wire logic                        watchdogRst, // Wd reset
	input wire logic                        monitorRst   // Mon reset
);
	import wrcm_pkg::*;
	logic disReg; // Reset-disable copy
	logic fwdReg; // Force-watchdog copy
	logic ienReg; // Irq enable copy

	function automatic logic hitAt(input logic [WIN_W-1:0] off);
		return address[ADDR_W-1:WIN_W] == blockBase
			&& address[WIN_W-1:0] == off;
	endfunction

	// Protected bits only move in special mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			disReg <= 1'b0;
			fwdReg <= 1'b0;
		end else if (wrStrobe && specialMode && hitAt(OFF_WD_CTRL)) begin
			disReg <= wrData[WDC_RST_DIS_BIT];
			fwdReg <= wrData[WDC_FWD_RST_BIT];
		end
	end

	// Enable is writable in any mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			ienReg <= 1'b0;
		else if (wrStrobe && hitAt(OFF_PI_CTRL))
			ienReg <= wrData[PIC_IRQ_EN_BIT];
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// Bad key byte while resets may pass
	sequence s_badKey;
		wrStrobe && hitAt(OFF_WD_KEY) && wrData != KEY_ARM
			&& wrData != KEY_RESTART;
	endsequence
	sequence s_gateOpen;
		!disReg && (!specialMode || fwdReg);
	endsequence

	a_bad_key_rst: assert property (
		s_badKey ##0 s_gateOpen |=> watchdogRst)
		else $error("Bad key gave no reset");
	a_wd_pulse: assert property (
		watchdogRst |=> !watchdogRst)
		else $error("Watchdog reset too long");
	a_dis_quiet: assert property (
		disReg && $past(disReg) |-> !watchdogRst && !monitorRst)
		else $error("Reset while disabled");
	a_fwd_gate: assert property (
		$past(specialMode) && !$past(fwdReg) |-> !watchdogRst)
		else $error("Special reset without force bit");
	a_mon_cause: assert property (
		monitorRst |-> $past(clockLost) && !$past(disReg))
		else $error("Monitor reset without cause");
	a_irq_enable: assert property (
		periodicIrq |-> ienReg)
		else $error("Irq while disabled");
	a_rd_idle: assert property (
		!$past(rdStrobe) |-> rdData == 8'h00)
		else $error("Read data outside read slot");
	a_rd_unmapped: assert property (
		rdStrobe && !hitAt(OFF_PI_CTRL) && !hitAt(OFF_PI_FLAG)
			&& !hitAt(OFF_WD_CTRL) |=> rdData == 8'h00)
		else $error("Unmapped read not zero");
endmodule // wrcm_core_chk

bind wrcm_core wrcm_core_chk u_chk (.clock(clock), .sys_rst(sys_rst),
	.address(address), .wrData(wrData), .wrStrobe(wrStrobe),
	.rdStrobe(rdStrobe), .rdData(rdData), .blockBase(blockBase),
	.specialMode(specialMode), .waitMode(waitMode), .bkgMode(bkgMode),
	.clockLost(clockLost), .periodicIrq(periodicIrq),
	.watchdogRst(watchdogRst), .monitorRst(monitorRst));

//--- tb_wrcm_core.sv
// Self-checking bench for the supervisory block
`timescale 1ns/10ps
module tb_wrcm_core;
	import wrcm_pkg::*;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdat;
		logic        spec;
		logic [7:0]  rexp;
	} wrcm_row_type;
	logic clock = 1'b0, sys_rst = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0;
	logic specialMode = 1'b0, waitMode = 1'b0, bkgMode = 1'b0;
	logic clockLost = 1'b0, periodicIrq, watchdogRst, monitorRst;
	logic [15:0]       address = 16'h0000;
	logic [7:0]        wrData = 8'h00, rdData, d;
	logic [BASE_W-1:0] blockBase = '0;
	int errTotal = 0, checkCount = 0, cycCnt = 0, rstCount = 0, t0, i;
	int wdShift [7] = '{0, 2, 4, 6, 8, 9, 10};
	// Write, read back; normal rows lock fields
	wrcm_row_type rows [11] = '{
		'{16'h0040, 8'hFF, 1'b0, 8'hE7}, '{16'h0040, 8'h01, 1'b0, 8'h61},
		'{16'h0042, 8'h00, 1'b0, 8'h00}, '{16'h0042, 8'hFF, 1'b0, 8'h80},
		'{16'h0040, 8'h10, 1'b1, 8'h10}, '{16'h0042, 8'h0B, 1'b1, 8'h0B},
		'{16'h0042, 8'h00, 1'b1, 8'h00}, '{16'h0040, 8'h00, 1'b1, 8'h00},
		'{16'h0044, 8'hFF, 1'b1, 8'h00}, '{16'h0840, 8'h80, 1'b1, 8'h00},
		'{16'h0043, 8'h55, 1'b1, 8'h00}};

	wrcm_core u_wrcm_core (.clock, .sys_rst, .address, .wrData, .wrStrobe,
		.rdStrobe, .rdData, .blockBase, .specialMode, .waitMode, .bkgMode,
		.clockLost, .periodicIrq, .watchdogRst, .monitorRst);

	// 25 MHz clock
	initial begin
		forever #20 clock = ~clock;
	end

	// Cycle count and watchdog pulse tally
	always @(posedge clock) begin
		cycCnt <= cycCnt + 1;
		if (watchdogRst === 1'b1)
			rstCount <= rstCount + 1;
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		address <= a;
		wrData <= v;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clock);
		address <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1 v = rdData;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Bounded wait for irq (0) or watchdog pulse (1)
	task automatic waitFor(input logic sel, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while ((sel ? watchdogRst : periodicIrq) !== 1'b1 && n < lim);
	endtask

	task automatic chk(input string nm, input logic [15:0] got, exp);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, well beyond the slowest rate loop
	initial begin
		repeat (60000) @(posedge clock);
		errTotal++;
		give_verdict;
	end

	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			rd(16'h0040 + 16'(i), d);
			chk("reset", d, i == 0 ? PIC_RESET : i == 2 ? WDC_RESET : 8'h00);
		end
		for (i = 0; i < 11; i++) begin
			specialMode <= rows[i].spec;
			wr(rows[i].addr, rows[i].wdat);
			rd(rows[i].addr, d);
			chk("readback", d, rows[i].rexp);
		end
		// Third flag interval is clean of rate-change effects
		for (i = 1; i < 8; i++) begin
			wr(16'h0040, 8'h90 | 8'(i));
			wr(16'h0041, 8'h80);
			waitFor(0, 600);
			wr(16'h0041, 8'h80);
			waitFor(0, 600);
			t0 = cycCnt;
			wr(16'h0041, 8'h80);
			waitFor(0, 600);
			chk("irq period", 16'(cycCnt - t0), 16'(4 << (i - 1)));
		end
		// Halt in wait, then in debug
		for (i = 0; i < 2; i++) begin
			waitMode <= (i == 0);
			bkgMode <= (i == 1);
			wr(16'h0040, i ? 8'hB1 : 8'hD1);
			wr(16'h0041, 8'h80);
			cyc(40);
			rd(16'h0041, d);
			chk("halted", d, 8'h00);
			waitMode <= 1'b0;
			bkgMode <= 1'b0;
			waitFor(0, 40);
			chk("resumed", periodicIrq, 1'b1);
		end
		wr(16'h0040, 8'h10);
		cyc(1);
		chk("masked irq", periodicIrq, 1'b0);
		wr(16'h0041, 8'h00);
		rd(16'h0041, d);
		chk("flag kept", d, 8'h80);
		wr(16'h0041, 8'h80);
		rd(16'h0041, d);
		chk("flag cleared", d, 8'h00);
		// Service with a read between the key bytes
		wr(16'h0042, 8'h13);
		t0 = rstCount;
		repeat (8) begin
			wr(16'h0043, KEY_ARM);
			rd(16'h0040, d);
			wr(16'h0043, KEY_RESTART);
			cyc(20);
		end
		chk("serviced", 16'(rstCount - t0), 16'h0000);
		cyc(80);
		chk("timeout", 16'(rstCount - t0), 16'h0001);
		for (i = 1; i < 8; i++) begin
			wr(16'h0042, 8'h10 | 8'(i));
			waitFor(1, 9000);
			t0 = cycCnt;
			waitFor(1, 9000);
			chk("wd period", 16'(cycCnt - t0), 16'(4 << wdShift[i - 1]));
		end
		wr(16'h0042, 8'h10);
		t0 = rstCount;
		wr(16'h0043, 8'h12);
		cyc(2);
		chk("bad key", 16'(rstCount - t0), 16'h0001);
		wr(16'h0042, 8'h18);
		wr(16'h0043, 8'h12);
		cyc(2);
		chk("key disabled", 16'(rstCount - t0), 16'h0001);
		wr(16'h0042, 8'hA0);
		clockLost <= 1'b1;
		cyc(3);
		chk("monitor", monitorRst, 1'b1);
		wr(16'h0042, 8'hA8);
		cyc(2);
		chk("mon disabled", monitorRst, 1'b0);
		wr(16'h0042, 8'h20);
		cyc(2);
		chk("mon off for stop", monitorRst, 1'b0);
		clockLost <= 1'b0;
		// Second reset with the flag set
		wr(16'h0040, 8'h91);
		waitFor(0, 40);
		sys_rst <= 1'b1;
		cyc(2);
		sys_rst <= 1'b0;
		specialMode <= 1'b0;
		rd(16'h0041, d);
		chk("flag at reset", d, 8'h00);
		wr(16'h0042, 8'h40);
		wr(16'h0042, 8'h00);
		clockLost <= 1'b1;
		cyc(3);
		chk("forced mon", monitorRst, 1'b1);
		clockLost <= 1'b0;
		blockBase <= 5'h03;
		rd(16'h1842, d);
		chk("moved window", d, 8'h40);
		give_verdict;
	end
endmodule // tb_wrcm_core
